// [sfcd_decoder.v]
// Command front end of a serial flash: decode, framing, flags
`timescale 1ns/1ps
`default_nettype none
`include "sfcd_defines.vh"
module sfcd_decoder (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Serial link pins
  input wire csN,
  input wire sclk,
  input wire [3:0] serialLaneIn,
  output wire [3:0] serialLaneOut,
  output wire [3:0] serialLaneOe,
  // Array engine status
  input wire engBusy,
  input wire engEraseFail,
  input wire engProgFail,
  input wire engVppFail,
  input wire eraseSusp,
  input wire progSusp,
  input wire protSectorHit,
  input wire otpLocked,
  input wire [7:0] rdByte,
  // Engine requests
  output wire execValid,
  output wire [7:0] execCode,
  output wire [23:0] execAddr,
  output wire rdActive,
  output wire rdNext,
  output wire [7:0] progData,
  output wire progValid,
  input wire progReady,
  // Mode state
  output wire [1:0] protocol,
  output wire deepPowerDown,
  output wire writeEnabled
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DIN = 3'h4;
  localparam ST_DOUT = 3'h5;
  localparam ST_HOLD = 3'h6;

  function [3:0] lanesOf;
    input [1:0] p;
    begin
      lanesOf = (p == `SFCD_P_QUAD) ? 4'h4 : (p == `SFCD_P_DUAL) ? 4'h2 : 4'h1;
    end
  endfunction

  // Address lanes high nibble, data lanes low nibble
  function [7:0] phaseLanes;
    input [7:0] c;
    input [1:0] p;
    begin
      if (p != `SFCD_P_EXT) phaseLanes = {lanesOf(p), lanesOf(p)};
      else begin
        case (c)
          `SFCD_C_DUALOUT, `SFCD_C_DPROG: phaseLanes = 8'h12;
          `SFCD_C_DUALIO, `SFCD_C_DPROGX: phaseLanes = 8'h22;
          `SFCD_C_QUADOUT, `SFCD_C_QPROG: phaseLanes = 8'h14;
          `SFCD_C_QUADIO, `SFCD_C_QPROGX: phaseLanes = 8'h44;
          default: phaseLanes = 8'h11;
        endcase
      end
    end
  endfunction

  function [7:0] shiftIn;
    input [7:0] sh;
    input [3:0] l;
    input [3:0] n;
    begin
      case (n)
        4'h1: shiftIn = {sh[6:0], l[0]};
        4'h2: shiftIn = {sh[5:0], l[1:0]};
        default: shiftIn = {sh[3:0], l};
      endcase
    end
  endfunction

  // Extended single lane talks out on lane 1
  function [3:0] laneDrive;
    input [7:0] b;
    input [3:0] n;
    begin
      case (n)
        4'h1: laneDrive = {2'b00, b[7], 1'b0};
        4'h2: laneDrive = {2'b00, b[7:6]};
        default: laneDrive = b[7:4];
      endcase
    end
  endfunction

  function [7:0] shiftOut;
    input [7:0] b;
    input [3:0] n;
    begin
      case (n)
        4'h1: shiftOut = {b[6:0], 1'b0};
        4'h2: shiftOut = {b[5:0], 2'b00};
        default: shiftOut = {b[3:0], 4'h0};
      endcase
    end
  endfunction

  // Result: ok, needs write enable, address, dummy, kind
  function [7:0] decode;
    input [7:0] c;
    input [1:0] p;
    input dpd;
    reg ext;
    begin
      ext = (p == `SFCD_P_EXT);
      decode = 8'h00;
      if (dpd) begin
        if (c == `SFCD_C_PUP) decode = {`SFCD_D_OK, `SFCD_K_SIMPLE};
      end else begin
        case (c)
          `SFCD_C_RSTEN, `SFCD_C_RSTMEM, `SFCD_C_WREN, `SFCD_C_WRDIS, `SFCD_C_CLRFLAG,
          `SFCD_C_PDOWN, `SFCD_C_PUP: decode = {`SFCD_D_OK, `SFCD_K_SIMPLE};
          `SFCD_C_RDSTAT, `SFCD_C_RDFLAG, `SFCD_C_RDNV, `SFCD_C_RDVC, `SFCD_C_RDEV:
            decode = {`SFCD_D_OK, `SFCD_K_RDREG};
          `SFCD_C_ID0, `SFCD_C_ID1: if (ext) decode = {`SFCD_D_OK, `SFCD_K_RDREG};
          `SFCD_C_IDMULTI: if (!ext) decode = {`SFCD_D_OK, `SFCD_K_RDREG};
          `SFCD_C_WRSTAT, `SFCD_C_WRVC, `SFCD_C_WREV, `SFCD_C_WRNV:
            decode = {`SFCD_D_OK | `SFCD_D_WEL, `SFCD_K_WRREG};
          `SFCD_C_READ: if (ext) decode = {`SFCD_D_OK | `SFCD_D_ADDR, `SFCD_K_READ};
          `SFCD_C_RDLOCK: decode = {`SFCD_D_OK | `SFCD_D_ADDR, `SFCD_K_READ};
          `SFCD_C_FAST, `SFCD_C_DISC, `SFCD_C_RDOTP:
            decode = {`SFCD_D_OK | `SFCD_D_ADDR | `SFCD_D_DUMMY, `SFCD_K_READ};
          `SFCD_C_DUALOUT, `SFCD_C_DUALIO: if (p != `SFCD_P_QUAD)
            decode = {`SFCD_D_OK | `SFCD_D_ADDR | `SFCD_D_DUMMY, `SFCD_K_READ};
          `SFCD_C_QUADOUT, `SFCD_C_QUADIO: if (p != `SFCD_P_DUAL)
            decode = {`SFCD_D_OK | `SFCD_D_ADDR | `SFCD_D_DUMMY, `SFCD_K_READ};
          `SFCD_C_PROG, `SFCD_C_PROGOTP:
            decode = {`SFCD_D_OK | `SFCD_D_WEL | `SFCD_D_ADDR, `SFCD_K_PROG};
          `SFCD_C_DPROG, `SFCD_C_DPROGX: if (p != `SFCD_P_QUAD)
            decode = {`SFCD_D_OK | `SFCD_D_WEL | `SFCD_D_ADDR, `SFCD_K_PROG};
          `SFCD_C_QPROG, `SFCD_C_QPROGX: if (p != `SFCD_P_DUAL)
            decode = {`SFCD_D_OK | `SFCD_D_WEL | `SFCD_D_ADDR, `SFCD_K_PROG};
          `SFCD_C_SUBERASE, `SFCD_C_SECERASE:
            decode = {`SFCD_D_OK | `SFCD_D_WEL | `SFCD_D_ADDR, `SFCD_K_ERASE};
          `SFCD_C_BULKERASE, `SFCD_C_SUSPEND, `SFCD_C_RESUME:
            decode = {`SFCD_D_OK | `SFCD_D_WEL, `SFCD_K_SIMPLE};
          default: decode = 8'h00;
        endcase
      end
    end
  endfunction

  reg csMeta_r, csSync_r, csPrev_r;
  reg sckMeta_r, sckSync_r, sckPrev_r;
  reg [3:0] laneMeta_r, laneSync_r;
  reg [2:0] st_r;
  reg [7:0] cmd_r, cls_r, inSh_r, outSh_r, wrB0_r, wrB1_r, pendData_r;
  reg [3:0] bitCnt_r, outCnt_r, dumCnt_r, laneOut_r, laneOe_r;
  reg [1:0] addrCnt_r, protocol_r;
  reg [23:0] addr_r, execAddr_r;
  reg [8:0] byteIdx_r;
  reg addrDone_r, pendVld_r, wel_r, dpd_r, rstArm_r, execValid_r, rdActive_r, rdNext_r;
  reg [7:0] execCode_r, vc_r, ev_r, srHigh_r;
  reg [15:0] nv_r;
  reg [3:0] err_r;
  reg [3:0] inLanes;
  reg [7:0] outByte;
  reg complete;
  wire bufReady;

  wire sckRise = sckSync_r & ~sckPrev_r;
  wire sckFall = ~sckSync_r & sckPrev_r;
  wire csRise = csSync_r & ~csPrev_r;
  wire csFall = ~csSync_r & csPrev_r;
  wire [7:0] phl = phaseLanes(cmd_r, protocol_r);
  wire [3:0] dLanes = phl[3:0];
  wire [7:0] newSh = shiftIn(inSh_r, laneSync_r, inLanes);
  wire [3:0] bitSum = bitCnt_r + inLanes;
  wire byteDone = (bitSum == 4'h8);
  wire [7:0] dec = decode(newSh, protocol_r, dpd_r);
  wire [3:0] kind = cls_r[3:0];
  wire [3:0] vcDummy = vc_r[7:4];
  wire [3:0] dumCycles = (vcDummy == 4'h0 || vcDummy == 4'hf) ?
    ((protocol_r == `SFCD_P_QUAD) ? `SFCD_DUMMY_QUAD : `SFCD_DUMMY_DEF) : vcDummy;
  wire [23:0] addrNext = {addr_r[15:0], newSh};
  wire [8:0] idxInc = (byteIdx_r == 9'h1ff) ? byteIdx_r : byteIdx_r + 9'h001;
  wire arrayOp = (kind == `SFCD_K_PROG) || (kind == `SFCD_K_ERASE) ||
    (cmd_r == `SFCD_C_BULKERASE);
  wire welOk = !cls_r[6] || wel_r;
  wire doCmd = csRise && complete && welOk;
  // Leftover error, protected sector or locked OTP area all refuse the array op
  wire protFail = arrayOp && ((|err_r) || protSectorHit ||
    (cmd_r == `SFCD_C_PROGOTP && otpLocked));
  wire [7:0] flagByte = {~engBusy, eraseSusp, err_r[3], err_r[2], err_r[1], progSusp,
    err_r[0], 1'b0};
  wire [1:0] evProto = !ev_r[`SFCD_EV_QUAD] ? `SFCD_P_QUAD :
    !ev_r[`SFCD_EV_DUAL] ? `SFCD_P_DUAL : `SFCD_P_EXT;

  always @* begin
    case (st_r)
      ST_ADDR, ST_DUMMY: inLanes = phl[7:4];
      ST_DIN: inLanes = dLanes;
      default: inLanes = lanesOf(protocol_r);
    endcase
  end

  // Live status is sampled at every byte slot so polling sees changes
  always @* begin
    case (cmd_r)
      `SFCD_C_RDSTAT: outByte = {srHigh_r[7:2], wel_r, engBusy};
      `SFCD_C_RDFLAG: outByte = flagByte;
      `SFCD_C_RDVC: outByte = vc_r;
      `SFCD_C_RDEV: outByte = ev_r;
      `SFCD_C_RDNV: outByte = (byteIdx_r == 9'h000) ? nv_r[7:0] :
        (byteIdx_r == 9'h001) ? nv_r[15:8] : 8'h00;
      `SFCD_C_ID0, `SFCD_C_ID1, `SFCD_C_IDMULTI: outByte = (byteIdx_r == 9'h000) ? `SFCD_ID_B0 :
        (byteIdx_r == 9'h001) ? `SFCD_ID_B1 : (byteIdx_r == 9'h002) ? `SFCD_ID_B2 : 8'h00;
      default: outByte = rdByte;
    endcase
  end

  // Writes only count when the frame ends on a byte boundary
  always @* begin
    complete = 1'b0;
    if (cls_r[7] && bitCnt_r == 4'h0) begin
      case (kind)
        `SFCD_K_SIMPLE: complete = (st_r == ST_HOLD);
        `SFCD_K_ERASE: complete = addrDone_r;
        `SFCD_K_PROG: complete = addrDone_r && byteIdx_r != 9'h000;
        `SFCD_K_WRREG: complete = (cmd_r == `SFCD_C_WRNV) ?
          (byteIdx_r >= `SFCD_NV_BYTES) : (byteIdx_r != 9'h000);
        default: complete = 1'b0;
      endcase
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      csMeta_r <= 1'b1;
      csSync_r <= 1'b1;
      csPrev_r <= 1'b1;
      sckMeta_r <= 1'b0;
      sckSync_r <= 1'b0;
      sckPrev_r <= 1'b0;
      laneMeta_r <= 4'h0;
      laneSync_r <= 4'h0;
    end else begin
      csMeta_r <= csN;
      csSync_r <= csMeta_r;
      csPrev_r <= csSync_r;
      sckMeta_r <= sclk;
      sckSync_r <= sckMeta_r;
      sckPrev_r <= sckSync_r;
      laneMeta_r <= serialLaneIn;
      laneSync_r <= laneMeta_r;
    end
  end

  // Error bits: engine or refusal sets, clear command clears, set wins
  always @(posedge clock or negedge nrst) begin
    if (!nrst) err_r <= 4'h0;
    else if (doCmd && cmd_r == `SFCD_C_CLRFLAG)
      err_r <= {engEraseFail, engProgFail, engVppFail, 1'b0};
    else
      err_r <= err_r | {engEraseFail, engProgFail, engVppFail, doCmd && protFail};
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      cmd_r <= 8'h00;
      cls_r <= 8'h00;
      inSh_r <= 8'h00;
      outSh_r <= 8'h00;
      wrB0_r <= 8'h00;
      wrB1_r <= 8'h00;
      pendData_r <= 8'h00;
      pendVld_r <= 1'b0;
      bitCnt_r <= 4'h0;
      outCnt_r <= 4'h0;
      dumCnt_r <= 4'h0;
      laneOut_r <= 4'h0;
      laneOe_r <= 4'h0;
      addrCnt_r <= 2'h0;
      addr_r <= 24'h000000;
      execAddr_r <= 24'h000000;
      byteIdx_r <= 9'h000;
      addrDone_r <= 1'b0;
      wel_r <= 1'b0;
      dpd_r <= 1'b0;
      rstArm_r <= 1'b0;
      execValid_r <= 1'b0;
      execCode_r <= 8'h00;
      rdActive_r <= 1'b0;
      rdNext_r <= 1'b0;
      vc_r <= `SFCD_VC_RESET;
      ev_r <= `SFCD_EV_RESET;
      nv_r <= `SFCD_NV_RESET;
      srHigh_r <= 8'h00;
      protocol_r <= `SFCD_P_EXT;
    end else begin
      execValid_r <= 1'b0;
      rdNext_r <= 1'b0;
      protocol_r <= evProto;
      if (pendVld_r && bufReady) pendVld_r <= 1'b0;
      if (csRise) begin
        st_r <= ST_IDLE;
        laneOe_r <= 4'h0;
        laneOut_r <= 4'h0;
        rdActive_r <= 1'b0;
        if (doCmd) begin
          rstArm_r <= (cmd_r == `SFCD_C_RSTEN);
          if (cls_r[6]) wel_r <= 1'b0;
          if (!protFail) begin
            execCode_r <= cmd_r;
            execValid_r <= cls_r[6];
            case (cmd_r)
              `SFCD_C_WREN: wel_r <= 1'b1;
              `SFCD_C_WRDIS: wel_r <= 1'b0;
              `SFCD_C_PDOWN: dpd_r <= 1'b1;
              `SFCD_C_PUP: dpd_r <= 1'b0;
              `SFCD_C_RSTMEM: if (rstArm_r) begin
                vc_r <= `SFCD_VC_RESET;
                ev_r <= `SFCD_EV_RESET;
                wel_r <= 1'b0;
              end
              `SFCD_C_WRSTAT: srHigh_r <= {wrB0_r[7:2], 2'b00};
              `SFCD_C_WRVC: vc_r <= wrB0_r;
              `SFCD_C_WREV: ev_r <= wrB0_r;
              `SFCD_C_WRNV: nv_r <= {wrB1_r, wrB0_r} | `SFCD_NV_RSVD;
              default: ;
            endcase
          end
        end
      end else if (csFall) begin
        st_r <= ST_CMD;
        cls_r <= 8'h00;
        bitCnt_r <= 4'h0;
        outCnt_r <= 4'h0;
        byteIdx_r <= 9'h000;
        addrCnt_r <= 2'h0;
        addrDone_r <= 1'b0;
      end else if (!csSync_r) begin
        if (sckRise) begin
          case (st_r)
            ST_CMD: begin
              inSh_r <= newSh;
              bitCnt_r <= byteDone ? 4'h0 : bitSum;
              if (byteDone) begin
                cmd_r <= newSh;
                cls_r <= dec;
                if (!dec[7]) st_r <= ST_HOLD;
                else if (dec[5]) st_r <= ST_ADDR;
                else if (dec[3:0] == `SFCD_K_RDREG) st_r <= ST_DOUT;
                else if (dec[3:0] == `SFCD_K_WRREG) st_r <= ST_DIN;
                else st_r <= ST_HOLD;
              end
            end
            ST_ADDR: begin
              inSh_r <= newSh;
              bitCnt_r <= byteDone ? 4'h0 : bitSum;
              if (byteDone) begin
                addr_r <= addrNext;
                addrCnt_r <= addrCnt_r + 2'h1;
                if (addrCnt_r == `SFCD_ADDR_BYTES - 2'h1) begin
                  addrDone_r <= 1'b1;
                  execAddr_r <= addrNext;
                  dumCnt_r <= dumCycles;
                  if (cls_r[4]) st_r <= ST_DUMMY;
                  else if (kind == `SFCD_K_READ) begin
                    st_r <= ST_DOUT;
                    rdActive_r <= 1'b1;
                  end else if (kind == `SFCD_K_PROG) st_r <= ST_DIN;
                  else st_r <= ST_HOLD;
                end
              end
            end
            ST_DUMMY: begin
              if (dumCnt_r == 4'h1) begin
                st_r <= ST_DOUT;
                rdActive_r <= 1'b1;
              end else dumCnt_r <= dumCnt_r - 4'h1;
            end
            ST_DIN: begin
              inSh_r <= newSh;
              bitCnt_r <= byteDone ? 4'h0 : bitSum;
              if (byteDone) begin
                byteIdx_r <= idxInc;
                if (kind == `SFCD_K_PROG) begin
                  pendData_r <= newSh;
                  pendVld_r <= 1'b1;
                end
                if (byteIdx_r == 9'h000) wrB0_r <= newSh;
                if (byteIdx_r == 9'h001) wrB1_r <= newSh;
              end
            end
            default: ;
          endcase
        end
        // Data change on the falling edge, half a period before sampling
        if (sckFall && st_r == ST_DOUT) begin
          laneOe_r <= laneDrive(8'hff, dLanes) | ((dLanes == 4'h1) ? 4'h0 : 4'h0);
          if (outCnt_r == 4'h0) begin
            laneOut_r <= laneDrive(outByte, dLanes);
            outSh_r <= shiftOut(outByte, dLanes);
            outCnt_r <= 4'h8 - dLanes;
            byteIdx_r <= idxInc;
            rdNext_r <= (kind == `SFCD_K_READ);
          end else begin
            laneOut_r <= laneDrive(outSh_r, dLanes);
            outSh_r <= shiftOut(outSh_r, dLanes);
            outCnt_r <= outCnt_r - dLanes;
          end
        end
      end
    end
  end

  // Held byte waits here while the buffer is full
  sfcd_buf2 progBuf (
    .clock(clock),
    .nrst(nrst),
    .inData(pendData_r),
    .inValid(pendVld_r),
    .inReady(bufReady),
    .outData(progData),
    .outValid(progValid),
    .outReady(progReady)
  );

  assign serialLaneOut = laneOut_r;
  assign serialLaneOe = laneOe_r;
  assign execValid = execValid_r;
  assign execCode = execCode_r;
  assign execAddr = execAddr_r;
  assign rdActive = rdActive_r;
  assign rdNext = rdNext_r;
  assign protocol = protocol_r;
  assign deepPowerDown = dpd_r;
  assign writeEnabled = wel_r;
endmodule
`default_nettype wire

// [sfcd_defines.vh]
// Constants for the serial flash command decoder
// What this block does
// - Protected program or erase sets protection flag
// - Flag register volatile, read by 70h
// - Status flags clear themselves when condition ends
// - Error flags stay until clear command 50h
// - Leftover error makes array command fail protected
// - Simple commands: no address, no dummy cycles
// - Plain read, programs, subsector and sector erases: three address bytes
// - Fast reads: address then dummy cycles from volatile config, 8/10 by default
// - Dual protocol takes 0Bh, 3Bh, BBh alike
// - Quad protocol takes 0Bh, 6Bh, EBh alike
// - Writes, programs, erases need write enable first
// - Identification reads limited by protocol
// - Dual/quad output reads limited by protocol
// - Dual program codes; 1 byte or more, no upper limit at 256
// - Quad program codes per protocol
// - B9h enters, ABh leaves deep power-down
// - Register read lanes follow active protocol
// - Chip select rise stops register output
// - Status readable anytime outside deep power-down, streams while selected
// - Flag register readable repeatedly anytime outside deep power-down
// - Nonvolatile config read low byte first
// - Flag bit 7 low while controller busy
// - Volatile config reads repeat same byte
// - Nonvolatile config: zeros after 16 bits
`ifndef SFCD_DEFINES_VH
`define SFCD_DEFINES_VH
`define SFCD_C_RSTEN 8'h66
`define SFCD_C_RSTMEM 8'h99
`define SFCD_C_ID0 8'h9e
`define SFCD_C_ID1 8'h9f
`define SFCD_C_IDMULTI 8'haf
`define SFCD_C_DISC 8'h5a
`define SFCD_C_READ 8'h03
`define SFCD_C_FAST 8'h0b
`define SFCD_C_DUALOUT 8'h3b
`define SFCD_C_DUALIO 8'hbb
`define SFCD_C_QUADOUT 8'h6b
`define SFCD_C_QUADIO 8'heb
`define SFCD_C_WREN 8'h06
`define SFCD_C_WRDIS 8'h04
`define SFCD_C_RDSTAT 8'h05
`define SFCD_C_WRSTAT 8'h01
`define SFCD_C_RDLOCK 8'he8
`define SFCD_C_RDFLAG 8'h70
`define SFCD_C_CLRFLAG 8'h50
`define SFCD_C_RDNV 8'hb5
`define SFCD_C_WRNV 8'hb1
`define SFCD_C_RDVC 8'h85
`define SFCD_C_WRVC 8'h81
`define SFCD_C_RDEV 8'h65
`define SFCD_C_WREV 8'h61
`define SFCD_C_PROG 8'h02
`define SFCD_C_DPROG 8'ha2
`define SFCD_C_DPROGX 8'hd2
`define SFCD_C_QPROG 8'h32
`define SFCD_C_QPROGX 8'h12
`define SFCD_C_SUBERASE 8'h20
`define SFCD_C_SECERASE 8'hd8
`define SFCD_C_BULKERASE 8'hc7
`define SFCD_C_RESUME 8'h7a
`define SFCD_C_SUSPEND 8'h75
`define SFCD_C_RDOTP 8'h4b
`define SFCD_C_PROGOTP 8'h42
`define SFCD_C_PDOWN 8'hb9
`define SFCD_C_PUP 8'hab
`define SFCD_P_EXT 2'h0
`define SFCD_P_DUAL 2'h1
`define SFCD_P_QUAD 2'h2
`define SFCD_K_SIMPLE 4'h0
`define SFCD_K_RDREG 4'h1
`define SFCD_K_WRREG 4'h2
`define SFCD_K_ERASE 4'h3
`define SFCD_K_PROG 4'h4
`define SFCD_K_READ 4'h5
`define SFCD_D_OK 4'h8
`define SFCD_D_WEL 4'h4
`define SFCD_D_ADDR 4'h2
`define SFCD_D_DUMMY 4'h1
`define SFCD_DUMMY_DEF 4'h8
`define SFCD_DUMMY_QUAD 4'ha
`define SFCD_ADDR_BYTES 2'h3
`define SFCD_NV_BYTES 9'h002
`define SFCD_VC_RESET 8'hfb
`define SFCD_EV_RESET 8'hdf
`define SFCD_NV_RESET 16'hffff
`define SFCD_NV_RSVD 16'h0010
`define SFCD_EV_QUAD 7
`define SFCD_EV_DUAL 6
`define SFCD_ID_B0 8'h5c
`define SFCD_ID_B1 8'h3a
`define SFCD_ID_B2 8'h17
`endif

// [sfcd_buf2.v]
// Two-entry byte buffer for program data
`timescale 1ns/1ps
`default_nettype none
module sfcd_buf2 (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Filling side
  input wire [7:0] inData,
  input wire inValid,
  output wire inReady,
  // Draining side
  output reg [7:0] outData,
  output reg outValid,
  input wire outReady
);
  reg [7:0] tail_r;
  reg tailVld_r;
  wire push = inValid && !tailVld_r;
  wire pop = outValid && outReady;

  assign inReady = !tailVld_r;

  // Head register feeds the port, so the drained data leave a flop
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      outData <= 8'h00;
      outValid <= 1'b0;
      tail_r <= 8'h00;
      tailVld_r <= 1'b0;
    end else if (pop || !outValid) begin
      if (tailVld_r) begin
        outData <= tail_r;
        outValid <= 1'b1;
        tailVld_r <= 1'b0;
      end else if (push) begin
        outData <= inData;
        outValid <= 1'b1;
      end else begin
        outValid <= 1'b0;
      end
    end else if (push) begin
      tail_r <= inData;
      tailVld_r <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [sfcd_assertions.sv]
// Port checker for the serial flash command decoder
`timescale 1ns/1ps
`default_nettype none
module sfcd_assertions (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Link
  input wire csN,
  input wire [3:0] serialLaneOe,
  // Engine side
  input wire execValid,
  input wire rdActive,
  input wire rdNext,
  input wire [7:0] progData,
  input wire progValid,
  input wire progReady,
  // Mode
  input wire [1:0] protocol,
  input wire deepPowerDown,
  input wire writeEnabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  reset_state_a: assert property ($rose(nrst) |-> serialLaneOe == 4'h0 && !writeEnabled
    && protocol == 2'h0) else $error("state not cleared by reset");
  oe_release_a: assert property ($rose(csN) |-> ##[1:5] serialLaneOe == 4'h0)
    else $error("lanes still driven after deselect");
  lane_width_a: assert property (serialLaneOe != 4'h0 && protocol != 2'h0 |->
    serialLaneOe == (protocol == 2'h1 ? 4'h3 : 4'hf)) else $error("lane count wrong");
  exec_wel_a: assert property ($rose(execValid) |-> $past(writeEnabled) && csN)
    else $error("command run without write enable");
  dpd_quiet_a: assert property (deepPowerDown |-> !rdActive && !execValid
    && serialLaneOe == 4'h0) else $error("activity in power-down");
  rd_gate_a: assert property (rdNext |-> rdActive || $past(rdActive))
    else $error("read byte taken outside read");
  prog_hold_a: assert property (progValid && !progReady |=> progValid
    && $stable(progData)) else $error("program byte lost in stall");
  mode_frame_a: assert property ($changed(protocol) || $changed(writeEnabled) |-> csN)
    else $error("mode changed inside frame");
  cover property (execValid);
  cover property (rdNext);
  cover property (progValid && !progReady);
endmodule
`default_nettype wire

// [sfcd_host_model.sv]
// Host serial controller model driving frames at the flash pins
`timescale 1ns/1ps
`default_nettype none
module sfcd_host_model (
  // Link pins seen from the host
  output logic csN,
  output logic sclk,
  output logic [3:0] hostLanes,
  input wire [3:0] lanes
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    hostLanes = 4'h0;
  end
  // Clock idles low between frames
  task automatic open_f;
    #30 csN = 1'b0;
    #30;
  endtask
  // Released lanes flip so a stale level never reads as valid
  task automatic close_f;
    #30 csN = 1'b1;
    sclk = 1'b0;
    hostLanes = ~hostLanes;
    #100;
  endtask
  // One byte MSB first on w lanes; returns what the device drove
  task automatic xfer(input logic [7:0] b, input int w, output logic [7:0] r);
    logic [7:0] t;
    t = b;
    r = 8'h00;
    repeat (8 / w) begin
      sclk = 1'b0;
      hostLanes = 4'(t >> (8 - w));
      t = t << w;
      #24 r = (r << w) | (w == 1 ? 8'(lanes[1]) : 8'(lanes & 4'((1 << w) - 1)));
      sclk = 1'b1;
      #24;
    end
  endtask
endmodule
`default_nettype wire

// [serial_flash_command_decoder_tb.sv]
// Self-checking bench for the serial flash command decoder
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_decoder_tb;
  typedef struct packed {logic [7:0] code; logic [2:0] eng; logic [7:0] e1; logic [7:0] e2;} sfcd_row_t;
  logic clock = 1'b0, nrst = 1'b0, progReady = 1'b0, protSectorHit = 1'b0;
  logic engBusy = 1'b0, eraseSusp = 1'b0, progSusp = 1'b0;
  logic [7:0] rdByte = 8'ha5;
  logic [7:0] got[3];
  wire csN, sclk, execValid, rdActive, rdNext, progValid, deepPowerDown, writeEnabled;
  wire [3:0] hostLanes, laneOut, laneOe;
  wire [3:0] lanes = (laneOe & laneOut) | (~laneOe & hostLanes);
  wire [7:0] execCode, progData;
  wire [23:0] execAddr;
  wire [1:0] protocol;
  int fail_count = 0, samples_checked = 0, execCount = 0;
  sfcd_row_t rows[7] = '{'{8'h70, 3'h0, 8'h80, 8'h80}, '{8'h70, 3'h7, 8'h44, 8'h44},
    '{8'h05, 3'h4, 8'h01, 8'h01}, '{8'h85, 3'h0, 8'hfb, 8'hfb}, '{8'h65, 3'h0, 8'hdf, 8'hdf},
    '{8'hb5, 3'h0, 8'hff, 8'hff}, '{8'h9e, 3'h0, 8'h5c, 8'h3a}};
  always #2.5 clock = ~clock;
  always @(negedge clock) if (execValid === 1'b1) execCount++;
  sfcd_host_model u_host (.csN(csN), .sclk(sclk), .hostLanes(hostLanes), .lanes(lanes));
  sfcd_decoder u_dut (.clock(clock), .nrst(nrst), .csN(csN), .sclk(sclk), .serialLaneIn(lanes),
    .serialLaneOut(laneOut), .serialLaneOe(laneOe), .engBusy(engBusy), .engEraseFail(1'b0),
    .engProgFail(1'b0), .engVppFail(1'b0), .eraseSusp(eraseSusp), .progSusp(progSusp),
    .protSectorHit(protSectorHit), .otpLocked(1'b0), .rdByte(rdByte), .execValid(execValid),
    .execCode(execCode), .execAddr(execAddr), .rdActive(rdActive), .rdNext(rdNext),
    .progData(progData), .progValid(progValid), .progReady(progReady), .protocol(protocol),
    .deepPowerDown(deepPowerDown), .writeEnabled(writeEnabled));
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Code, n bytes of d, then k bytes read back
  task automatic fr(input logic [7:0] c, input int w, input int n, input logic [39:0] d,
    input int k);
    logic [7:0] x;
    u_host.open_f();
    u_host.xfer(c, w, x);
    for (int i = 0; i < n; i++) u_host.xfer(d[39 - 8 * i -: 8], w, x);
    for (int i = 0; i < k; i++) begin
      u_host.xfer(8'h00, w, x);
      got[i] = x;
    end
    u_host.close_f();
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    foreach (rows[i]) begin
      @(negedge clock) {engBusy, eraseSusp, progSusp} = rows[i].eng;
      fr(rows[i].code, 1, 0, 0, 2);
      cmp("reg byte0", rows[i].e1, got[0]);
      cmp("reg byte1", rows[i].e2, got[1]);
    end
    fr(8'hb5, 1, 0, 0, 3);
    cmp("nv tail", 8'h00, got[2]);
    fr(8'h70, 1, 0, 0, 1);
    cmp("ready poll", 8'h80, got[0]);
    fr(8'h06, 1, 0, 0, 0);
    cmp("wel set", 1'h1, writeEnabled);
    fr(8'h02, 1, 4, 40'h0123453c00, 0);
    cmp("prog valid", 1'h1, progValid);
    cmp("prog data", 8'h3c, progData);
    @(negedge clock) progReady = 1'b1;
    cmp("exec count", 1, execCount);
    cmp("exec code", 8'h02, execCode);
    cmp("exec addr", 24'h012345, execAddr);
    cmp("wel clear", 1'h0, writeEnabled);
    fr(8'h02, 1, 4, 40'h0123453c00, 0);
    cmp("no wel exec", 1, execCount);
    @(negedge clock) protSectorHit = 1'b1;
    fr(8'h06, 1, 0, 0, 0);
    fr(8'hd8, 1, 3, 40'h0100000000, 0);
    @(negedge clock) protSectorHit = 1'b0;
    fr(8'h06, 1, 0, 0, 0);
    fr(8'h20, 1, 3, 40'h0200000000, 0);
    cmp("stale error", 1, execCount);
    fr(8'h70, 1, 0, 0, 2);
    cmp("prot flag", 8'h82, got[0]);
    cmp("prot sticky", 8'h82, got[1]);
    fr(8'h50, 1, 0, 0, 0);
    fr(8'h70, 1, 0, 0, 1);
    cmp("flag cleared", 8'h80, got[0]);
    fr(8'haf, 1, 0, 0, 1);
    cmp("multi id ext", 8'h00, got[0]);
    fr(8'hff, 1, 0, 0, 1);
    cmp("undefined", 8'h00, got[0]);
    fr(8'h03, 1, 3, 40'h0000100000, 1);
    cmp("plain read", 8'ha5, got[0]);
    cmp("read end", 1'h0, rdActive);
    fr(8'h0b, 1, 4, 40'h0000100000, 1);
    cmp("fast read", 8'ha5, got[0]);
    fr(8'hb9, 1, 0, 0, 0);
    cmp("dpd on", 1'h1, deepPowerDown);
    fr(8'h70, 1, 0, 0, 1);
    cmp("dpd quiet", 8'h00, got[0]);
    fr(8'hab, 1, 0, 0, 0);
    cmp("dpd off", 1'h0, deepPowerDown);
    fr(8'h06, 1, 0, 0, 0);
    fr(8'h61, 1, 1, 40'h9f00000000, 0);
    cmp("dual mode", 2'h1, protocol);
    fr(8'h70, 2, 0, 0, 1);
    cmp("dual flag", 8'h80, got[0]);
    fr(8'h3b, 2, 5, 40'h0000100000, 1);
    cmp("dual alias", 8'ha5, got[0]);
    fr(8'h66, 2, 0, 0, 0);
    fr(8'h99, 2, 0, 0, 0);
    cmp("sw reset", 2'h0, protocol);
    fr(8'h06, 1, 0, 0, 0);
    fr(8'h61, 1, 1, 40'h7f00000000, 0);
    cmp("quad mode", 2'h2, protocol);
    fr(8'h06, 4, 0, 0, 0);
    fr(8'h81, 4, 1, 40'h4b00000000, 0);
    fr(8'heb, 4, 5, 40'h0000100000, 1);
    cmp("quad alias", 8'ha5, got[0]);
    fr(8'h66, 4, 0, 0, 0);
    fr(8'h99, 4, 0, 0, 0);
    fr(8'h06, 1, 0, 0, 0);
    fr(8'hb1, 1, 2, 40'h2481000000, 0);
    fr(8'hb5, 1, 0, 0, 2);
    cmp("nv low", 8'h34, got[0]);
    cmp("nv high", 8'h81, got[1]);
    fr(8'h06, 1, 0, 0, 0);
    @(negedge clock) nrst = 1'b0;
    repeat (3) @(negedge clock);
    cmp("reset wel", 1'h0, writeEnabled);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    fr(8'h70, 1, 0, 0, 1);
    cmp("flag after reset", 8'h80, got[0]);
    tally_and_finish();
  end
endmodule
bind sfcd_decoder sfcd_assertions u_chk (.clock(clock), .nrst(nrst), .csN(csN),
  .serialLaneOe(serialLaneOe), .execValid(execValid), .rdActive(rdActive), .rdNext(rdNext),
  .progData(progData), .progValid(progValid), .progReady(progReady), .protocol(protocol),
  .deepPowerDown(deepPowerDown), .writeEnabled(writeEnabled));
`default_nettype wire
